// *** verification/ceiu_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ceiu_bus_model
   import ceiu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ceiu_bus_t bus,
   input wire logic slow,
   output logic bus_ack,
   output logic [7:0] bus_rdata
);
   logic [7:0] mem [256];
   logic [7:0] io [256];
   int writes;
   logic [1:0] cnt;
   // Read data toggles while idle so stale values never look valid.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_ack <= 1'b0;
         bus_rdata <= 8'h00;
         cnt <= 2'h0;
         writes <= 0;
      end else if (bus_ack) begin
         bus_ack <= 1'b0;
         cnt <= 2'h0;
         bus_rdata <= ~bus_rdata;
         if (bus.write) begin
            writes <= writes + 1;
            if (bus.io) begin
               io[bus.addr[7:0]] <= bus.wdata;
            end else begin
               mem[bus.addr[7:0]] <= bus.wdata;
            end
         end
      end else if (bus.req && (!slow || cnt == 2'h3)) begin
         bus_ack <= 1'b1;
         bus_rdata <= bus.io ? io[bus.addr[7:0]] : mem[bus.addr[7:0]];
      end else begin
         cnt <= bus.req ? cnt + 2'h1 : 2'h0;
         bus_rdata <= ~bus_rdata;
      end
   end
endmodule : ceiu_bus_model
`default_nettype wire

// *** verification/ceiu_exec_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ceiu_exec_chk
   import ceiu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire ceiu_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic done,
   input wire logic cmd_error,
   input wire ceiu_bus_t bus,
   input wire logic bus_ack,
   input wire logic wake,
   input wire logic sleeping,
   input wire ceiu_regs_t regs
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   logic in_ptest;
   assign take = cmd_valid && cmd_ready;
   // Remembers that a port test is under way, so no write may appear.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_ptest <= 1'b0;
      end else if (take) begin
         in_ptest <= (cmd.op == PORT_TEST_INSTRUCTION);
      end else if (done) begin
         in_ptest <= 1'b0;
      end
   end
   property p_io_high;
      bus.req && bus.io |-> bus.addr[15:8] == CEIU_IO_HIGH;
   endproperty
   a_io_high: assert property (p_io_high)
      else $error("io upper address not zero");
   property p_bus_hold;
      bus.req && !bus_ack |=> bus.req && $stable(bus.addr)
         && $stable(bus.wdata) && $stable(bus.write);
   endproperty
   a_bus_hold: assert property (p_bus_hold)
      else $error("bus request changed before ack");
   property p_sleep;
      take && cmd.op == SLEEP_ENTRY_INSTRUCTION |=> done && sleeping;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep not entered");
   property p_stay_asleep;
      sleeping && !wake |=> sleeping && !cmd_ready;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep)
      else $error("left sleep without wake");
   property p_mult;
      take && cmd.op == UNSIGNED_MULTIPLY_INSTRUCTION
         && cmd.sel[1:0] == CEIU_PAIR_DE |=> {regs.prim.d, regs.prim.e}
         == {8'h00, $past(regs.prim.d)} * {8'h00, $past(regs.prim.e)};
   endproperty
   a_mult: assert property (p_mult)
      else $error("wrong product");
   property p_test_imm;
      take && cmd.op == TEST_IMMEDIATE |=> done
         && regs.prim.a == $past(regs.prim.a) && regs.prim.f[CEIU_FLAG_Z]
         == (($past(regs.prim.a) & $past(cmd.imm)) == 8'h00);
   endproperty
   a_test_imm: assert property (p_test_imm)
      else $error("immediate test wrong");
   property p_test_reg;
      take && cmd.op == TEST_REGISTER && cmd.sel == CEIU_REG_B |=>
         regs.prim.f[CEIU_FLAG_PV]
         == ~^($past(regs.prim.a) & $past(regs.prim.b))
         && regs.prim.f[CEIU_FLAG_S]
         == ($past(regs.prim.a[7]) & $past(regs.prim.b[7]))
         && regs.prim.b == $past(regs.prim.b);
   endproperty
   a_test_reg: assert property (p_test_reg)
      else $error("register test wrong");
   property p_pc_moves;
      $changed(regs.pc) |-> done && !cmd_error;
   endproperty
   a_pc_moves: assert property (p_pc_moves)
      else $error("pc moved outside retire");
   property p_ptest;
      in_ptest && bus.req |-> !bus.write;
   endproperty
   a_ptest: assert property (p_ptest)
      else $error("port test wrote the bus");
endmodule : ceiu_exec_chk
bind ceiu_exec ceiu_exec_chk ceiu_exec_chk_i (.clk(clk), .rst(rst),
   .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .done(done),
   .cmd_error(cmd_error), .bus(bus), .bus_ack(bus_ack), .wake(wake),
   .sleeping(sleeping), .regs(regs));
`default_nettype wire

// *** verification/ceiu_exec_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ceiu_exec_tb
   import ceiu_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   ceiu_cmd_t cmd = '0;
   logic wake = 1'b0;
   logic slow = 1'b0;
   logic cmd_ready, done, cmd_error, sleeping, bus_ack, last_err;
   logic [7:0] bus_rdata;
   ceiu_bus_t bus;
   ceiu_regs_t regs;
   int miscompares = 0;
   int check_count = 0;
   logic [15:0] exp_pc = 16'h0000;
   always #12.5 clk = ~clk;
   ceiu_exec ceiu_exec_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .cmd_error(cmd_error),
      .bus(bus), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .wake(wake),
      .sleeping(sleeping), .regs(regs));
   ceiu_bus_model ceiu_bus_model_i (.clk(clk), .rst(rst), .bus(bus),
      .slow(slow), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
   task automatic check(input logic [15:0] seen, input logic [15:0] want,
      input string what);
      check_count++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %0t %s saw %h want %h", $time, what, seen, want);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   task automatic issue(input ceiu_op_t op, input logic [2:0] sel,
      input logic [7:0] imm);
      int n;
      @(negedge clk);
      cmd = '{op: op, sel: sel, imm: imm, len: 2'h2};
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) miscompares++;
      last_err = cmd_error;
      if (last_err !== 1'b1) exp_pc = exp_pc + 16'h0002;
      check(regs.pc, exp_pc, "pc");
   endtask : issue
   task automatic load(input logic [2:0] sel, input logic [7:0] v);
      ceiu_bus_model_i.io[8'hF0] = v;
      issue(SHORT_ADDRESS_INPUT, sel, 8'hF0);
   endtask : load
   function automatic logic [7:0] expf(input logic [7:0] r);
      return {r[7], r == 8'h00, 1'b0, 1'b1, 1'b0, ~^r, 1'b0, 1'b0};
   endfunction : expf
   task automatic t_reset();
      check(regs.pc, 16'h0000, "pc reset");
      check(regs.sp | regs.ix | regs.iy, 16'h0000, "words reset");
      check({sleeping, cmd_ready}, 16'h0001, "idle");
      $display("finished reset test");
   endtask : t_reset
   task automatic t_short();
      load(CEIU_REG_B, 8'h5A);
      check(regs.prim.b, 8'h5A, "in0");
      issue(SHORT_ADDRESS_OUTPUT, CEIU_REG_B, 8'h21);
      check(ceiu_bus_model_i.io[8'h21], 8'h5A, "short_address_output");
      $display("finished short io test");
   endtask : t_short
   task automatic t_mult();
      logic [7:0] hi [3] = '{8'h0C, 8'hFF, 8'h80};
      logic [7:0] lo [3] = '{8'h0B, 8'hFF, 8'h02};
      logic [15:0] pr [3];
      for (int i = 0; i < 3; i++) begin
         load(3'(2 * i), hi[i]);
         load(3'(2 * i + 1), lo[i]);
         issue(UNSIGNED_MULTIPLY_INSTRUCTION, 3'(i), 8'h00);
         pr = '{{regs.prim.b, regs.prim.c}, {regs.prim.d, regs.prim.e},
            {regs.prim.h, regs.prim.l}};
         check(pr[i], 16'(hi[i]) * 16'(lo[i]), "product");
      end
      issue(UNSIGNED_MULTIPLY_INSTRUCTION, 3'(CEIU_PAIR_SP), 8'h00);
      check(regs.sp, 16'h0000, "sp product");
      $display("finished multiply test");
   endtask : t_mult
   task automatic t_tests();
      int w0;
      load(CEIU_REG_A, 8'h81);
      issue(TEST_IMMEDIATE, 3'h0, 8'h80);
      check(regs.prim.f & 8'hD7, expf(8'h80), "tst m");
      issue(TEST_IMMEDIATE, 3'h0, 8'h7E);
      check(regs.prim.f & 8'hD7, expf(8'h00), "tst zero");
      load(CEIU_REG_B, 8'h03);
      issue(TEST_REGISTER, CEIU_REG_B, 8'h00);
      check(regs.prim.f & 8'hD7, expf(8'h01), "tst g");
      check({regs.prim.a, regs.prim.b}, 16'h8103, "tst g keep");
      load(CEIU_REG_H, 8'h00);
      load(CEIU_REG_L, 8'h50);
      load(CEIU_REG_C, 8'h60);
      ceiu_bus_model_i.mem[8'h50] = 8'hF1;
      ceiu_bus_model_i.io[8'h60] = 8'h0F;
      w0 = ceiu_bus_model_i.writes;
      issue(TEST_MEMORY, 3'h0, 8'h00);
      check(regs.prim.f & 8'hD7, expf(8'h81), "tst hl");
      check(regs.prim.a, 8'h81, "tst hl keep");
      issue(PORT_TEST_INSTRUCTION, 3'h0, 8'h3C);
      check(regs.prim.f & 8'hD7, expf(8'h0C), "port_test_instruction");
      check(16'(ceiu_bus_model_i.writes - w0), 16'h0000, "no write");
      issue(TEST_REGISTER, CEIU_REG_NONE, 8'h00);
      check(last_err, 1'b1, "bad sel");
      $display("finished test instructions");
   endtask : t_tests
   task automatic t_block();
      ceiu_op_t ops [4] = '{BLOCK_OUT_INC_SINGLE, BLOCK_OUT_INC_REPEAT,
         BLOCK_OUT_DEC_SINGLE, BLOCK_OUT_DEC_REPEAT};
      int steps;
      int w0;
      logic [7:0] p;
      logic [7:0] d;
      for (int k = 0; k < 4; k++) begin
         slow = k[0];
         steps = k[0] ? 3 : 1;
         p = k < 2 ? 8'h80 : 8'h8F;
         for (int j = 0; j < 3; j++) begin
            d = k < 2 ? 8'(j) : 8'(-j);
            ceiu_bus_model_i.mem[p + d] = 8'(8'hA0 + 16 * k + j);
         end
         load(CEIU_REG_H, 8'h00);
         load(CEIU_REG_L, p);
         load(CEIU_REG_C, p ^ 8'h40);
         load(CEIU_REG_B, 8'h03);
         w0 = ceiu_bus_model_i.writes;
         issue(ops[k], 3'h0, 8'h00);
         for (int j = 0; j < steps; j++) begin
            d = k < 2 ? 8'(j) : 8'(-j);
            check(ceiu_bus_model_i.io[(p ^ 8'h40) + d],
               ceiu_bus_model_i.mem[p + d], "block data");
         end
         d = k < 2 ? 8'(steps) : 8'(-steps);
         check({regs.prim.h, regs.prim.l}, {8'h00, p + d}, "hl");
         check(regs.prim.c, 8'((p ^ 8'h40) + d), "port");
         check(regs.prim.b, 8'(3 - steps), "count");
         check(16'(ceiu_bus_model_i.writes - w0), 16'(steps), "outs");
      end
      slow = 1'b0;
      $display("finished block output test");
   endtask : t_block
   task automatic t_exchange();
      load(CEIU_REG_A, 8'h3E);
      issue(EXCHANGE_ACC_FLAGS, 3'h0, 8'h00);
      check({regs.alt.a, regs.prim.a}, 16'h3E00, "ex af");
      load(CEIU_REG_B, 8'h77);
      issue(EXCHANGE_PAIRS, 3'h0, 8'h00);
      check({regs.alt.b, regs.prim.b}, 16'h7700, "exx");
      issue(EXCHANGE_PAIRS, 3'h0, 8'h00);
      check(regs.prim.b, 8'h77, "exx back");
      $display("finished exchange test");
   endtask : t_exchange
   task automatic t_sleep();
      issue(SLEEP_ENTRY_INSTRUCTION, 3'h0, 8'h00);
      check(sleeping, 1'b1, "asleep");
      cmd = '{op: TEST_IMMEDIATE, sel: 3'h0, imm: 8'h00, len: 2'h2};
      cmd_valid = 1'b1;
      repeat (4) begin
         @(negedge clk);
         check({sleeping, cmd_ready}, 16'h0002, "refused");
      end
      cmd_valid = 1'b0;
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      check(sleeping, 1'b0, "woken");
      check(regs.pc, exp_pc, "pc after sleep");
      $display("finished sleep test");
   endtask : t_sleep
   initial begin
      #500000;
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_short();
      t_mult();
      t_tests();
      t_block();
      t_exchange();
      t_sleep();
      wrap_up();
   end
endmodule : ceiu_exec_tb
`default_nettype wire

// *** verilog/ceiu_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module ceiu_exec
   import ceiu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire ceiu_cmd_t cmd,
   output logic cmd_ready,
   output logic done,
   output logic cmd_error,
   output ceiu_bus_t bus,
   input wire logic bus_ack,
   input wire logic [7:0] bus_rdata,
   input wire logic wake,
   output logic sleeping,
   output ceiu_regs_t regs
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MEM_RD,
      ST_IO_WR,
      ST_IO_RD,
      ST_SLEEP
   } ceiu_state_t;

   ceiu_state_t state;
   ceiu_state_t next_state;
   ceiu_cmd_t cur;
   ceiu_cmd_t next_cur;
   ceiu_bus_t next_bus;
   logic next_done;
   logic next_error;
   ceiu_wr_t wr;
   logic [7:0] test_a;
   logic [7:0] test_b;
   logic [7:0] test_flags;
   logic [15:0] hl;
   logic [15:0] hl_next;
   logic [7:0] count_next;
   logic is_dec;
   logic is_repeat;
   logic [15:0] mult_src;

   ceiu_regfile u_regfile (
      .clk(clk),
      .rst(rst),
      .wr(wr),
      .regs(regs)
   );

   ceiu_test_unit u_test (
      .opnd_a(test_a),
      .opnd_b(test_b),
      .flags_in(regs.prim.f),
      .flags_out(test_flags)
   );

   assign cmd_ready = (state == ST_IDLE);
   assign sleeping = (state == ST_SLEEP);
   assign hl = {regs.prim.h, regs.prim.l};

   always_comb begin
      is_dec = (cur.op == BLOCK_OUT_DEC_SINGLE) ||
               (cur.op == BLOCK_OUT_DEC_REPEAT);
      is_repeat = (cur.op == BLOCK_OUT_INC_REPEAT) ||
                  (cur.op == BLOCK_OUT_DEC_REPEAT);
      hl_next = is_dec ? hl - CEIU_ONE16 : hl + CEIU_ONE16;
      count_next = regs.prim.b - CEIU_ONE8;
      mult_src = ceiu_get16(regs, cmd.sel[1:0]);
   end

   always_comb begin
      next_state = state;
      next_cur = cur;
      next_bus = bus;
      next_done = 1'b0;
      next_error = 1'b0;
      wr = '0;
      wr.len = cur.len;
      test_a = regs.prim.a;
      test_b = regs.prim.a;
      unique case (state)
         ST_IDLE: begin
            next_bus.req = 1'b0;
            wr.len = cmd.len;
            if (cmd_valid) begin
               next_cur = cmd;
               unique case (cmd.op)
                  SLEEP_ENTRY_INSTRUCTION: begin
                     wr.retire = 1'b1;
                     next_done = 1'b1;
                     next_state = ST_SLEEP;
                  end
                  UNSIGNED_MULTIPLY_INSTRUCTION: begin
                     // Only two bits select the pair, so no other register
                     // can ever be named.
                     wr.wr16 = 1'b1;
                     wr.sel16 = cmd.sel[1:0];
                     wr.d16 = 16'(mult_src[15:8] * mult_src[7:0]);
                     wr.retire = 1'b1;
                     next_done = 1'b1;
                  end
                  BLOCK_OUT_INC_SINGLE, BLOCK_OUT_INC_REPEAT,
                  BLOCK_OUT_DEC_SINGLE, BLOCK_OUT_DEC_REPEAT,
                  TEST_MEMORY: begin
                     next_bus.req = 1'b1;
                     next_bus.io = 1'b0;
                     next_bus.write = 1'b0;
                     next_bus.addr = hl;
                     next_bus.wdata = CEIU_BYTE_RESET;
                     next_state = ST_MEM_RD;
                  end
                  PORT_TEST_INSTRUCTION: begin
                     next_bus.req = 1'b1;
                     next_bus.io = 1'b1;
                     next_bus.write = 1'b0;
                     next_bus.addr = {CEIU_IO_HIGH, regs.prim.c};
                     next_bus.wdata = CEIU_BYTE_RESET;
                     next_state = ST_IO_RD;
                  end
                  TEST_REGISTER: begin
                     if (cmd.sel == CEIU_REG_NONE) begin
                        next_error = 1'b1;
                     end else begin
                        test_b = ceiu_get8(regs.prim, cmd.sel);
                        wr.wrf = 1'b1;
                        wr.f = test_flags;
                        wr.retire = 1'b1;
                     end
                     next_done = 1'b1;
                  end
                  TEST_IMMEDIATE: begin
                     test_b = cmd.imm;
                     wr.wrf = 1'b1;
                     wr.f = test_flags;
                     wr.retire = 1'b1;
                     next_done = 1'b1;
                  end
                  SHORT_ADDRESS_INPUT: begin
                     next_bus.req = 1'b1;
                     next_bus.io = 1'b1;
                     next_bus.write = 1'b0;
                     next_bus.addr = {CEIU_IO_HIGH, cmd.imm};
                     next_bus.wdata = CEIU_BYTE_RESET;
                     next_state = ST_IO_RD;
                  end
                  SHORT_ADDRESS_OUTPUT: begin
                     next_bus.req = 1'b1;
                     next_bus.io = 1'b1;
                     next_bus.write = 1'b1;
                     next_bus.addr = {CEIU_IO_HIGH, cmd.imm};
                     next_bus.wdata = ceiu_get8(regs.prim, cmd.sel);
                     next_state = ST_IO_WR;
                  end
                  EXCHANGE_ACC_FLAGS: begin
                     wr.ex_af = 1'b1;
                     wr.retire = 1'b1;
                     next_done = 1'b1;
                  end
                  EXCHANGE_PAIRS: begin
                     wr.exx = 1'b1;
                     wr.retire = 1'b1;
                     next_done = 1'b1;
                  end
                  default: begin
                     next_error = 1'b1;
                     next_done = 1'b1;
                  end
               endcase
            end
         end
         ST_MEM_RD: begin
            if (bus_ack) begin
               if (cur.op == TEST_MEMORY) begin
                  test_b = bus_rdata;
                  wr.wrf = 1'b1;
                  wr.f = test_flags;
                  wr.retire = 1'b1;
                  next_done = 1'b1;
                  next_bus.req = 1'b0;
                  next_state = ST_IDLE;
               end else begin
                  next_bus.io = 1'b1;
                  next_bus.write = 1'b1;
                  next_bus.addr = {CEIU_IO_HIGH, regs.prim.c};
                  next_bus.wdata = bus_rdata;
                  next_state = ST_IO_WR;
               end
            end
         end
         ST_IO_WR: begin
            if (bus_ack) begin
               if (cur.op == SHORT_ADDRESS_OUTPUT) begin
                  wr.retire = 1'b1;
                  next_done = 1'b1;
                  next_bus.req = 1'b0;
                  next_state = ST_IDLE;
               end else begin
                  wr.blk_step = 1'b1;
                  wr.blk_dec = is_dec;
                  // The loop test uses the count after this step.
                  if (is_repeat && (count_next != CEIU_BYTE_RESET)) begin
                     next_bus.io = 1'b0;
                     next_bus.write = 1'b0;
                     next_bus.addr = hl_next;
                     next_bus.wdata = CEIU_BYTE_RESET;
                     next_state = ST_MEM_RD;
                  end else begin
                     wr.retire = 1'b1;
                     next_done = 1'b1;
                     next_bus.req = 1'b0;
                     next_state = ST_IDLE;
                  end
               end
            end
         end
         ST_IO_RD: begin
            if (bus_ack) begin
               if (cur.op == PORT_TEST_INSTRUCTION) begin
                  test_a = bus_rdata;
                  test_b = cur.imm;
                  wr.wrf = 1'b1;
                  wr.f = test_flags;
               end else begin
                  wr.wr8 = 1'b1;
                  wr.sel8 = cur.sel;
                  wr.d8 = bus_rdata;
               end
               wr.retire = 1'b1;
               next_done = 1'b1;
               next_bus.req = 1'b0;
               next_state = ST_IDLE;
            end
         end
         ST_SLEEP: begin
            next_bus.req = 1'b0;
            if (wake) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         cur <= '0;
         bus <= '0;
         done <= 1'b0;
         cmd_error <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         bus <= next_bus;
         done <= next_done;
         cmd_error <= next_error;
      end
   end

endmodule : ceiu_exec
`default_nettype wire

// *** verilog/ceiu_pkg.sv ***
package ceiu_pkg;

   localparam logic [15:0] CEIU_PC_RESET = 16'h0000;
   localparam logic [15:0] CEIU_WORD_RESET = 16'h0000;
   localparam logic [7:0] CEIU_BYTE_RESET = 8'h00;
   localparam logic [7:0] CEIU_IO_HIGH = 8'h00;
   localparam logic [7:0] CEIU_ONE8 = 8'h01;
   localparam logic [15:0] CEIU_ONE16 = 16'h0001;

   localparam int CEIU_FLAG_S = 7;
   localparam int CEIU_FLAG_Z = 6;
   localparam int CEIU_FLAG_H = 4;
   localparam int CEIU_FLAG_PV = 2;
   localparam int CEIU_FLAG_N = 1;
   localparam int CEIU_FLAG_C = 0;

   localparam logic [2:0] CEIU_REG_B = 3'h0;
   localparam logic [2:0] CEIU_REG_C = 3'h1;
   localparam logic [2:0] CEIU_REG_D = 3'h2;
   localparam logic [2:0] CEIU_REG_E = 3'h3;
   localparam logic [2:0] CEIU_REG_H = 3'h4;
   localparam logic [2:0] CEIU_REG_L = 3'h5;
   localparam logic [2:0] CEIU_REG_NONE = 3'h6;
   localparam logic [2:0] CEIU_REG_A = 3'h7;

   localparam logic [1:0] CEIU_PAIR_BC = 2'h0;
   localparam logic [1:0] CEIU_PAIR_DE = 2'h1;
   localparam logic [1:0] CEIU_PAIR_HL = 2'h2;
   localparam logic [1:0] CEIU_PAIR_SP = 2'h3;

   typedef enum logic [3:0] {
      SLEEP_ENTRY_INSTRUCTION,
      UNSIGNED_MULTIPLY_INSTRUCTION,
      BLOCK_OUT_INC_SINGLE,
      BLOCK_OUT_INC_REPEAT,
      BLOCK_OUT_DEC_SINGLE,
      BLOCK_OUT_DEC_REPEAT,
      PORT_TEST_INSTRUCTION,
      TEST_REGISTER,
      TEST_IMMEDIATE,
      TEST_MEMORY,
      SHORT_ADDRESS_INPUT,
      SHORT_ADDRESS_OUTPUT,
      EXCHANGE_ACC_FLAGS,
      EXCHANGE_PAIRS
   } ceiu_op_t;

   typedef struct packed {
      ceiu_op_t op;
      logic [2:0] sel;
      logic [7:0] imm;
      logic [1:0] len;
   } ceiu_cmd_t;

   typedef struct packed {
      logic req;
      logic io;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ceiu_bus_t;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] f;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
      logic [7:0] e;
      logic [7:0] h;
      logic [7:0] l;
   } ceiu_set_t;

   typedef struct packed {
      ceiu_set_t prim;
      ceiu_set_t alt;
      logic [7:0] ivec;
      logic [7:0] refresh;
      logic [15:0] ix;
      logic [15:0] iy;
      logic [15:0] sp;
      logic [15:0] pc;
   } ceiu_regs_t;

   typedef struct packed {
      logic wr8;
      logic [2:0] sel8;
      logic [7:0] d8;
      logic wr16;
      logic [1:0] sel16;
      logic [15:0] d16;
      logic wrf;
      logic [7:0] f;
      logic blk_step;
      logic blk_dec;
      logic ex_af;
      logic exx;
      logic retire;
      logic [1:0] len;
   } ceiu_wr_t;

   function automatic logic [7:0] ceiu_get8(ceiu_set_t s, logic [2:0] sel);
      logic [7:0] v;
      v = s.a;
      unique case (sel)
         CEIU_REG_B: v = s.b;
         CEIU_REG_C: v = s.c;
         CEIU_REG_D: v = s.d;
         CEIU_REG_E: v = s.e;
         CEIU_REG_H: v = s.h;
         CEIU_REG_L: v = s.l;
         default: v = s.a;
      endcase
      return v;
   endfunction : ceiu_get8

   function automatic logic [15:0] ceiu_get16(ceiu_regs_t r, logic [1:0] sel);
      logic [15:0] v;
      unique case (sel)
         CEIU_PAIR_BC: v = {r.prim.b, r.prim.c};
         CEIU_PAIR_DE: v = {r.prim.d, r.prim.e};
         CEIU_PAIR_HL: v = {r.prim.h, r.prim.l};
         CEIU_PAIR_SP: v = r.sp;
      endcase
      return v;
   endfunction : ceiu_get16

endpackage : ceiu_pkg

// *** verilog/ceiu_regfile.sv ***
`timescale 1ns/1ps
`default_nettype none
module ceiu_regfile
   import ceiu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ceiu_wr_t wr,
   output ceiu_regs_t regs
);

   ceiu_regs_t next_regs;
   logic [15:0] hl_step;

   always_comb begin
      next_regs = regs;
      hl_step = {regs.prim.h, regs.prim.l};
      if (wr.wr8) begin
         unique case (wr.sel8)
            CEIU_REG_B: next_regs.prim.b = wr.d8;
            CEIU_REG_C: next_regs.prim.c = wr.d8;
            CEIU_REG_D: next_regs.prim.d = wr.d8;
            CEIU_REG_E: next_regs.prim.e = wr.d8;
            CEIU_REG_H: next_regs.prim.h = wr.d8;
            CEIU_REG_L: next_regs.prim.l = wr.d8;
            CEIU_REG_A: next_regs.prim.a = wr.d8;
            default: next_regs.prim.a = regs.prim.a;
         endcase
      end
      if (wr.wr16) begin
         unique case (wr.sel16)
            CEIU_PAIR_BC: {next_regs.prim.b, next_regs.prim.c} = wr.d16;
            CEIU_PAIR_DE: {next_regs.prim.d, next_regs.prim.e} = wr.d16;
            CEIU_PAIR_HL: {next_regs.prim.h, next_regs.prim.l} = wr.d16;
            CEIU_PAIR_SP: next_regs.sp = wr.d16;
         endcase
      end
      if (wr.wrf) begin
         next_regs.prim.f = wr.f;
      end
      if (wr.blk_step) begin
         if (wr.blk_dec) begin
            hl_step = {regs.prim.h, regs.prim.l} - CEIU_ONE16;
            next_regs.prim.c = regs.prim.c - CEIU_ONE8;
         end else begin
            hl_step = {regs.prim.h, regs.prim.l} + CEIU_ONE16;
            next_regs.prim.c = regs.prim.c + CEIU_ONE8;
         end
         {next_regs.prim.h, next_regs.prim.l} = hl_step;
         next_regs.prim.b = regs.prim.b - CEIU_ONE8;
      end
      // Exchanges swap A and F, or B, C, D, E, H and L, in one cycle; the alternate set has no
      // other write path, so it cannot be addressed directly.
      if (wr.ex_af) begin
         next_regs.prim.a = regs.alt.a;
         next_regs.prim.f = regs.alt.f;
         next_regs.alt.a = regs.prim.a;
         next_regs.alt.f = regs.prim.f;
      end
      if (wr.exx) begin
         {next_regs.prim.b, next_regs.prim.c, next_regs.prim.d,
          next_regs.prim.e, next_regs.prim.h, next_regs.prim.l} =
            {regs.alt.b, regs.alt.c, regs.alt.d,
             regs.alt.e, regs.alt.h, regs.alt.l};
         {next_regs.alt.b, next_regs.alt.c, next_regs.alt.d,
          next_regs.alt.e, next_regs.alt.h, next_regs.alt.l} =
            {regs.prim.b, regs.prim.c, regs.prim.d,
             regs.prim.e, regs.prim.h, regs.prim.l};
      end
      if (wr.retire) begin
         next_regs.pc = regs.pc + {14'h0000, wr.len};
         // Only the low seven bits of the refresh counter count.
         next_regs.refresh = {regs.refresh[7],
                              7'(regs.refresh[6:0] + 7'h01)};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regs.prim <= '0;
         regs.alt <= '0;
         regs.ivec <= CEIU_BYTE_RESET;
         regs.refresh <= CEIU_BYTE_RESET;
         regs.ix <= CEIU_WORD_RESET;
         regs.iy <= CEIU_WORD_RESET;
         regs.sp <= CEIU_WORD_RESET;
         regs.pc <= CEIU_PC_RESET;
      end else begin
         regs <= next_regs;
      end
   end

endmodule : ceiu_regfile
`default_nettype wire

// *** verilog/ceiu_test_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module ceiu_test_unit
   import ceiu_pkg::*;
(
   input wire logic [7:0] opnd_a,
   input wire logic [7:0] opnd_b,
   input wire logic [7:0] flags_in,
   output logic [7:0] flags_out
);

   logic [7:0] result;

   always_comb begin
      result = opnd_a & opnd_b;
      // Unused flag bits 5 and 3 keep their old value.
      flags_out = flags_in;
      flags_out[CEIU_FLAG_S] = result[7];
      flags_out[CEIU_FLAG_Z] = (result == CEIU_BYTE_RESET);
      flags_out[CEIU_FLAG_H] = 1'b1;
      flags_out[CEIU_FLAG_PV] = ~^result;
      flags_out[CEIU_FLAG_N] = 1'b0;
      flags_out[CEIU_FLAG_C] = 1'b0;
   end

endmodule : ceiu_test_unit
`default_nettype wire
